// ==== logic/anadv_pkg.sv ====
// Package: register map, field layout and types of the advertisement block
`default_nettype none
package anadv_pkg;
   // Bus geometry
   localparam int          ANADV_ADDR_W      = 4;
   localparam int          ANADV_DATA_W      = 32;
   localparam int          ANADV_REG_W       = 16;
   // Register index as printed, byte address is four times it
   localparam logic [3:0]  ANADV_ADVERT_IDX  = 4'h4;
   // Reset value of the whole register
   localparam logic [15:0] ANADV_ADVERT_RST  = 16'h01E1;
   // Field positions
   localparam int          ANADV_NP_BIT      = 15;
   localparam int          ANADV_RSV14_BIT   = 14;
   localparam int          ANADV_RF_BIT      = 13;
   localparam int          ANADV_TECH_LSB    = 5;
   localparam int          ANADV_TECH_MSB    = 8;
   localparam int          ANADV_SEL_LSB     = 0;
   localparam int          ANADV_SEL_MSB     = 4;
   localparam int          ANADV_TECH_W      = 4;
   localparam int          ANADV_SEL_W       = 5;
   // Fixed and reset field values
   localparam logic        ANADV_NP_VAL      = 1'b0;
   localparam logic        ANADV_RF_RST      = 1'b0;
   localparam logic [3:0]  ANADV_TECH_RST    = 4'hF;
   localparam logic [4:0]  ANADV_SEL_VAL     = 5'h01;
   // Bit within tech field for 10BASE-T full duplex
   localparam int          ANADV_TECH_10FD   = 1;
   // Answer on unmapped reads
   localparam logic [31:0] ANADV_UNMAPPED    = 32'h0000_0000;
   localparam logic [31:0] ANADV_ZERO32      = 32'h0000_0000;

   // Writable content of the advertisement
   typedef struct packed {
      logic       remote_fault_adv;
      logic [3:0] tech;
   } anadv_abil_t;

   // Avalon-MM request from the master
   typedef struct packed {
      logic [3:0]  address;
      logic        read;
      logic        write;
      logic [3:0]  byteenable;
      logic [31:0] writedata;
   } anadv_req_t;

   typedef enum logic [2:0] {
      ANADV_IDLE = 3'b001,
      ANADV_ACK  = 3'b010,
      ANADV_DONE = 3'b100
   } anadv_state_t;
endpackage
`default_nettype wire

// ==== logic/anadv_regfile.sv ====
// Advertisement register image: assemble the 16-bit view from fields
`timescale 1ns/1ps
`default_nettype none
module anadv_regfile
   import anadv_pkg::*;
(
   input  wire anadv_pkg::anadv_abil_t stored,
   output logic [15:0]                 advert_reg
);
   import anadv_pkg::*;

   always_comb
   begin
      advert_reg = 16'h0000;
      advert_reg[ANADV_NP_BIT] = ANADV_NP_VAL;
      advert_reg[ANADV_RF_BIT] = stored.remote_fault_adv;
      advert_reg[ANADV_TECH_MSB:ANADV_TECH_LSB] = stored.tech;
      advert_reg[ANADV_SEL_MSB:ANADV_SEL_LSB] = ANADV_SEL_VAL;
   end
endmodule // anadv_regfile
`default_nettype wire

// ==== logic/anadv_store.sv ====
// Generic resettable storage register with load strobe
`timescale 1ns/1ps
`default_nettype none
module anadv_store #(
   parameter int                W   = 5,
   parameter logic [W-1:0]      RST = '0
) (
   input  wire logic            clk_sys,
   input  wire logic            reset,
   input  wire logic            load,
   input  wire logic [W-1:0]    d,
   output logic      [W-1:0]    q_ff
);
   always_ff @(posedge clk_sys)
   begin
      if (reset)
         q_ff <= RST;
      else if (load)
         q_ff <= d;
   end
endmodule // anadv_store
`default_nettype wire

// ==== logic/anadv_top.sv ====
// Auto-negotiation advertisement register with Avalon-MM slave
`timescale 1ns/1ps
`default_nettype none
module anadv_top
   import anadv_pkg::*;
(
   input  wire logic                  clk_sys,
   input  wire logic                  reset,
   input  wire anadv_pkg::anadv_req_t avs_req,
   output logic [31:0]                avs_readdata_ff,
   output logic                       avs_waitrequest_ff,
   input  wire logic                  an_restart,
   output logic                       remote_fault_adv_ff,
   output logic [3:0]                 tech_ability_ff,
   output logic                       next_page_able_ff,
   output logic [4:0]                 selector_ff,
   output logic                       tenfd_adv_ff
);
   import anadv_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   anadv_state_t state_ff;
   anadv_state_t nxt_state;
   anadv_abil_t  stored;
   anadv_abil_t  nxt_stored;
   logic [15:0]  advert_reg;
   logic         hit;
   logic         wr_take;
   logic         rd_take;
   logic         store_load;

   // Word-aligned address index must equal the printed register index
   assign hit = (avs_req.address == ANADV_ADVERT_IDX);

   // Request accepted in ACK state, one wait cycle for a request starting in IDLE, two if it starts in DONE
   assign wr_take = (state_ff == ANADV_ACK) && avs_req.write;
   assign rd_take = (state_ff == ANADV_ACK) && avs_req.read;

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         ANADV_IDLE:
            if (avs_req.read || avs_req.write)
               nxt_state = ANADV_ACK;
         ANADV_ACK:
            nxt_state = ANADV_DONE;
         ANADV_DONE:
            nxt_state = ANADV_IDLE;
         default:
            nxt_state = ANADV_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         state_ff <= ANADV_IDLE;
      else
         state_ff <= nxt_state;
   end

   // Waitrequest high except in the single acknowledge cycle
   always_ff @(posedge clk_sys)
   begin
      if (reset)
         avs_waitrequest_ff <= 1'b1;
      else
         avs_waitrequest_ff <= (nxt_state != ANADV_ACK);
   end

   ////////////////////////////////////////////////////////////////////////
   // Only bytes 0 and 1 carry the register; reserved bits are dropped
   always_comb
   begin
      nxt_stored = stored;
      if (avs_req.byteenable[1])
         nxt_stored.remote_fault_adv = avs_req.writedata[ANADV_RF_BIT];
      if (avs_req.byteenable[1])
         nxt_stored.tech[ANADV_TECH_W-1] =
            avs_req.writedata[ANADV_TECH_MSB];
      if (avs_req.byteenable[0])
         nxt_stored.tech[ANADV_TECH_W-2:0] =
            avs_req.writedata[ANADV_TECH_MSB-1:ANADV_TECH_LSB];
   end

   assign store_load = wr_take && hit;

   anadv_store #(
      .W   ($bits(anadv_abil_t)),
      .RST ({ANADV_RF_RST, ANADV_TECH_RST})
   ) u_store (
      .clk_sys (clk_sys),
      .reset   (reset),
      .load    (store_load),
      .d       (nxt_stored),
      .q_ff    (stored)
   );

   anadv_regfile u_image (
      .stored     (stored),
      .advert_reg (advert_reg)
   );

   // Read data valid in the acknowledge cycle
   always_ff @(posedge clk_sys)
   begin
      if (reset)
         avs_readdata_ff <= ANADV_ZERO32;
      else if (nxt_state == ANADV_ACK && avs_req.read)
         avs_readdata_ff <= (hit ? {16'h0000, advert_reg}
                                 : ANADV_UNMAPPED);
      else
         avs_readdata_ff <= ANADV_ZERO32;
   end

   ////////////////////////////////////////////////////////////////////////
   // Advertised abilities move only on a restart; a write racing the
   // restart is not seen until the next restart
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         remote_fault_adv_ff <= ANADV_RF_RST;
         tech_ability_ff     <= ANADV_TECH_RST;
      end
      else if (an_restart)
      begin
         remote_fault_adv_ff <= stored.remote_fault_adv;
         tech_ability_ff     <= stored.tech;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         next_page_able_ff <= ANADV_NP_VAL;
         selector_ff       <= ANADV_SEL_VAL;
         tenfd_adv_ff      <= ANADV_TECH_RST[ANADV_TECH_10FD];
      end
      else
      begin
         next_page_able_ff <= ANADV_NP_VAL;
         selector_ff       <= ANADV_SEL_VAL;
         if (an_restart)
            tenfd_adv_ff <= stored.tech[ANADV_TECH_10FD];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Advertised side: moves only on a restart, and then to the stored copy
   a_write_no_effect: assert property (
      @(posedge clk_sys) disable iff (reset)
      !an_restart
      |=> $stable(tech_ability_ff) && $stable(remote_fault_adv_ff)
   )
   else
      $error("advertised abilities changed without restart");

   a_restart_copies: assert property (
      @(posedge clk_sys) disable iff (reset)
      an_restart
      |=> tech_ability_ff == $past(stored.tech)
   )
   else
      $error("restart did not publish stored tech");

   a_rf_published: assert property (
      @(posedge clk_sys) disable iff (reset)
      an_restart
      |=> remote_fault_adv_ff == $past(stored.remote_fault_adv)
   )
   else
      $error("restart did not publish remote fault");

   a_latch_then_pass: assert property (
      @(posedge clk_sys) disable iff (reset)
      store_load ##[1:3] an_restart
      |=> remote_fault_adv_ff == $past(stored.remote_fault_adv)
         && tech_ability_ff == $past(stored.tech)
   )
   else
      $error("latched value not passed on restart");

   a_tenfd_follows: assert property (
      @(posedge clk_sys) disable iff (reset)
      tenfd_adv_ff == tech_ability_ff[ANADV_TECH_10FD]
   )
   else
      $error("10BASE-T full duplex mismatch");

   ////////////////////////////////////////////////////////////////////////
   // Stored copy: loads only on a mapped write, per byte lane
   a_write_stores: assert property (
      @(posedge clk_sys) disable iff (reset)
      store_load && avs_req.byteenable == 4'hF
      |=> stored.tech ==
             $past(avs_req.writedata[ANADV_TECH_MSB:ANADV_TECH_LSB])
   )
   else
      $error("written tech bits not stored");

   a_rf_stores: assert property (
      @(posedge clk_sys) disable iff (reset)
      store_load && avs_req.byteenable[1]
      |=> stored.remote_fault_adv ==
             $past(avs_req.writedata[ANADV_RF_BIT])
   )
   else
      $error("remote fault bit not stored");

   a_store_hold: assert property (
      @(posedge clk_sys) disable iff (reset)
      !store_load
      |=> $stable(stored)
   )
   else
      $error("stored abilities changed without a write");

   ////////////////////////////////////////////////////////////////////////
   // Register image and outputs: fixed fields, reset value and unmapped reads
   a_fixed_bits: assert property (
      @(posedge clk_sys) disable iff (reset)
      advert_reg[ANADV_NP_BIT:ANADV_RSV14_BIT] == '0
         && advert_reg[ANADV_RF_BIT-1:ANADV_TECH_MSB+1] == '0
   )
   else
      $error("reserved or next page bit not zero");

   a_np_fixed: assert property (
      @(posedge clk_sys) disable iff (reset)
      next_page_able_ff == ANADV_NP_VAL
   )
   else
      $error("next page ability not fixed");

   a_selector_fixed: assert property (
      @(posedge clk_sys) disable iff (reset)
      advert_reg[ANADV_SEL_MSB:ANADV_SEL_LSB] == ANADV_SEL_VAL
         && selector_ff == ANADV_SEL_VAL
   )
   else
      $error("selector not fixed");

   // Checked on the first edge after release, mid-run releases too
   a_reset_value: assert property (
      @(posedge clk_sys)
      $fell(reset)
      |-> advert_reg == ANADV_ADVERT_RST
         && tech_ability_ff == ANADV_TECH_RST
         && avs_waitrequest_ff
   )
   else
      $error("register not at reset value");

   a_unmapped_read: assert property (
      @(posedge clk_sys) disable iff (reset)
      rd_take && !hit
      |-> avs_readdata_ff == ANADV_UNMAPPED
   )
   else
      $error("unmapped read returned data");

   ////////////////////////////////////////////////////////////////////////
   // Bus handshake: one answer cycle per request, data only while it stands
   a_answer_time: assert property (
      @(posedge clk_sys) disable iff (reset)
      state_ff == ANADV_IDLE && (avs_req.read || avs_req.write)
      |=> !avs_waitrequest_ff
   )
   else
      $error("slave answer late");

   a_wait_one_cycle: assert property (
      @(posedge clk_sys) disable iff (reset)
      !avs_waitrequest_ff
      |=> avs_waitrequest_ff
   )
   else
      $error("waitrequest low for more than one cycle");

   a_rdata_idle_zero: assert property (
      @(posedge clk_sys) disable iff (reset)
      avs_waitrequest_ff
      |-> avs_readdata_ff == ANADV_ZERO32
   )
   else
      $error("read data outside the answer cycle");

   ////////////////////////////////////////////////////////////////////////
   c_write: cover property (
      @(posedge clk_sys) store_load
   );
   c_read: cover property (
      @(posedge clk_sys) rd_take && hit
   );
   c_restart: cover property (
      @(posedge clk_sys) store_load ##[1:4] an_restart
   );
   c_unmapped: cover property (
      @(posedge clk_sys) rd_take && !hit
   );
   c_tenfd_off: cover property (
      @(posedge clk_sys) an_restart ##1 !tenfd_adv_ff
   );
endmodule // anadv_top
`default_nettype wire

// ==== tb/anadv_partner.sv ====
// Link partner stand-in: requests restarts, records advertised word
`timescale 1ns/1ps
`default_nettype none
module anadv_partner
(
   input  wire logic       clk_sys,
   input  wire logic       np,
   input  wire logic       rf,
   input  wire logic [3:0] tech,
   input  wire logic [4:0] sel,
   output logic            an_restart,
   output logic [15:0]     heard_ff
);
   initial an_restart = 1'b0;
   // Partner sees only the outputs, never the register image
   always_ff @(posedge clk_sys)
   begin
      heard_ff <= {np, 1'b0, rf, 4'h0, tech, sel};
   end
   // One-cycle restart, then wait until the heard word has settled
   task automatic restart();
      begin
         an_restart <= 1'b1;
         @(posedge clk_sys);
         an_restart <= 1'b0;
         @(posedge clk_sys);
         @(posedge clk_sys);
      end
   endtask
endmodule // anadv_partner
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the advertisement register block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import anadv_pkg::*;
   logic        clk_sys;
   logic        reset;
   anadv_req_t  avs_req;
   logic [31:0] avs_readdata_ff;
   logic        avs_waitrequest_ff;
   logic        an_restart;
   logic        rf_ff;
   logic [3:0]  tech_ff;
   logic        np_ff;
   logic [4:0]  sel_ff;
   logic        tenfd_ff;
   logic [15:0] heard;
   logic [31:0] rd;
   int          failures;
   int          num_checks;
   int          cycles;

   anadv_top anadv_top_i (.clk_sys(clk_sys), .reset(reset),
      .avs_req(avs_req), .avs_readdata_ff(avs_readdata_ff),
      .avs_waitrequest_ff(avs_waitrequest_ff), .an_restart(an_restart),
      .remote_fault_adv_ff(rf_ff), .tech_ability_ff(tech_ff),
      .next_page_able_ff(np_ff), .selector_ff(sel_ff),
      .tenfd_adv_ff(tenfd_ff));
   anadv_partner anadv_partner_i (.clk_sys(clk_sys), .np(np_ff),
      .rf(rf_ff), .tech(tech_ff), .sel(sel_ff), .an_restart(an_restart),
      .heard_ff(heard));

   always #5 clk_sys = ~clk_sys;
   ////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      if (failures == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask

   // Hold request until waitrequest is sampled low, then release
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [3:0] be, input logic [31:0] d);
      avs_req <= '{address:a, read:!wr, write:wr, byteenable:be,
                   writedata:d};
      @(posedge clk_sys);
      while (avs_waitrequest_ff !== 1'b0)
         @(posedge clk_sys);
      rd = avs_readdata_ff;
      avs_req.read  <= 1'b0;
      avs_req.write <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic check_adv(input logic [15:0] e);
      check({15'h0, tenfd_ff, np_ff, 1'b0, rf_ff, 4'h0, tech_ff, sel_ff},
         {15'h0, e[6], e});
   endtask
   ////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      bus(1'b0, 4'h4, 4'hF, 32'h0);
      check(rd, 32'h0000_01E1);
      check_adv(16'h01E1);
   endtask

   task automatic t_write_all();
      bus(1'b1, 4'h4, 4'hF, 32'hFFFF_FFFF);
      bus(1'b0, 4'h4, 4'hF, 32'h0);
      check(rd, 32'h0000_21E1);
      check_adv(16'h01E1);
      anadv_partner_i.restart();
      check_adv(16'h21E1);
      check({16'h0, heard}, 32'h0000_21E1);
   endtask

   // Byte 0 alone reaches tech bits 7:5 only
   task automatic t_lanes();
      bus(1'b1, 4'h4, 4'h1, 32'h0);
      bus(1'b0, 4'h4, 4'hF, 32'h0);
      check(rd, 32'h0000_2101);
      anadv_partner_i.restart();
      check_adv(16'h2101);
   endtask

   task automatic t_tenfd();
      bus(1'b1, 4'h4, 4'h3, 32'h0000_01A1);
      bus(1'b0, 4'h4, 4'hF, 32'h0);
      check(rd, 32'h0000_01A1);
      anadv_partner_i.restart();
      check_adv(16'h01A1);
   endtask

   task automatic t_unmapped();
      bus(1'b1, 4'h5, 4'hF, 32'hFFFF_FFFF);
      bus(1'b0, 4'h5, 4'hF, 32'h0);
      check(rd, 32'h0);
      bus(1'b0, 4'h4, 4'hF, 32'h0);
      check(rd, 32'h0000_01A1);
   endtask

   // Read-modify-write keeps reserved bits, restart at once, then reset
   task automatic t_rmw_reset();
      bus(1'b0, 4'h4, 4'hF, 32'h0);
      bus(1'b1, 4'h4, 4'hF, rd | 32'h0000_2000);
      anadv_partner_i.restart();
      check_adv(16'h21A1);
      reset <= 1'b1;
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      check_adv(16'h01E1);
      bus(1'b0, 4'h4, 4'hF, 32'h0);
      check(rd, 32'h0000_01E1);
   endtask
   ////////////////////////////////////////////////////////////////////
   // Ceiling well above the fewer than one hundred cycles the sequence needs
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         failures++;
         report_and_stop();
      end
   end

   initial
   begin
      clk_sys = 1'b0;
      reset = 1'b1;
      avs_req = '0;
      failures = 0;
      num_checks = 0;
      cycles = 0;
      repeat (10) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      t_reset();
      t_write_all();
      t_lanes();
      t_tenfd();
      t_unmapped();
      t_rmw_reset();
      report_and_stop();
   end
endmodule // testbench
`default_nettype wire
